// *** logic/cdt_map.svh ***
// register offsets, field positions, reset values and timing counts
// for the cascadable dual 8-bit timer; assumes 12-bit APB byte addresses
`ifndef CDT_MAP_SVH
`define CDT_MAP_SVH

// register byte offsets (one aligned word each)
`define CDT_OFF_CTRL0      12'h000
`define CDT_OFF_CTRL1      12'h004
`define CDT_OFF_CSR0       12'h008
`define CDT_OFF_CSR1       12'h00C
`define CDT_OFF_CNT0       12'h010
`define CDT_OFF_CNT1       12'h014
`define CDT_OFF_CMPA0      12'h018
`define CDT_OFF_CMPA1      12'h01C
`define CDT_OFF_CMPB0      12'h020
`define CDT_OFF_CMPB1      12'h024
`define CDT_OFF_IRQ_STAT   12'h028
`define CDT_OFF_IRQ_MASK   12'h02C

// control word: clock select [2:0], clear select [4:3]
`define CDT_CKS_LSB        0
`define CDT_CCLR_LSB       3
// ctl/status word: output select [3:0], channel flags [6:4]
`define CDT_OS_LSB         0
`define CDT_FLAG_LSB       4

// clock select codes
`define CDT_CKS_PCLK       3'h1
`define CDT_CKS_DIV8       3'h2
`define CDT_CKS_DIV64      3'h3
`define CDT_CKS_CASCADE    3'h4

// clear select codes
`define CDT_CCLR_NONE      2'h0
`define CDT_CCLR_MATCH_A   2'h1
`define CDT_CCLR_MATCH_B   2'h2
`define CDT_CCLR_PIN       2'h3

// output action codes (per match letter)
`define CDT_OS_KEEP        2'h0
`define CDT_OS_LOW         2'h1
`define CDT_OS_HIGH        2'h2
`define CDT_OS_TOGGLE      2'h3

// interrupt status bit positions
`define CDT_IRQ_CMFA0      0
`define CDT_IRQ_CMFB0      1
`define CDT_IRQ_OVF0       2
`define CDT_IRQ_CMFA1      3
`define CDT_IRQ_CMFB1      4
`define CDT_IRQ_OVF1       5

// reset values
`define CDT_RST_BYTE       8'h00
`define CDT_RST_COMPARE    8'hFF
`define CDT_RST_IRQ        6'h00

// prescaler terminal counts and the counter byte maximum
`define CDT_DIV8_TC        3'h7
`define CDT_DIV64_TC       6'h3F
`define CDT_BYTE_MAX       8'hFF

`endif

// *** logic/cdt_pkg.sv ***
// types of the cascadable dual 8-bit timer
// assumes cdt_map.svh supplies all numbers
`default_nettype none
package cdt_pkg;
    // complete register and pipeline state of the timer
    typedef struct packed {
        logic [2:0]  src0;
        logic [2:0]  src1;
        logic [1:0]  clrm0;
        logic [1:0]  clrm1;
        logic [3:0]  act0;
        logic [3:0]  act1;
        logic [7:0]  cnt0;
        logic [7:0]  cnt1;
        logic [7:0]  cmpa0;
        logic [7:0]  cmpa1;
        logic [7:0]  cmpb0;
        logic [7:0]  cmpb1;
        logic [5:0]  stat;
        logic [5:0]  mask;
        logic [5:0]  div;
        logic [2:0]  ext0;
        logic [2:0]  ext1;
        logic        wave0;
        logic        wave1;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cdt_state_t;
endpackage : cdt_pkg
`default_nettype wire

// *** logic/cdt_timer.sv ***
// cascadable dual 8-bit timer with APB register access
// assumes a 100 MHz pclk, asynchronous active-low presetn, and that the
// external clear pins are asynchronous to pclk
//
// Function
// R1: match A action code 00 keeps, 01 drives low, 10 drives high, 11 toggles.
// R2: match B action code 11 toggles the output on every match B.
// R3: match B action code 00 keeps, 01 drives low, 10 drives high.
// R4: on simultaneous matches toggle beats high and high beats low.
// R5: outputs are low from reset and held low while all select bits are 0.
// R6: clock code 100 in either channel cascades the two channels.
// R7: ch0 code 100 forms one 16-bit counter, ch0 high byte, ch1 low byte.
// R8: in 16-bit mode ch0 flags set on a full 16-bit compare match.
// R9: in 16-bit mode ch1 flags set on a low-byte compare match.
// R10: in 16-bit mode a ch0 match clear clears both bytes, pin clear too.
// R11: in 16-bit mode ch1 clear select is ignored.
// R12: in 16-bit mode ch0 output follows 16-bit matches.
// R13: in 16-bit mode ch1 output follows low-byte matches.
// R14: ch1 code 100 makes ch1 count ch0 match A events.
// R15: in match counter mode each channel keeps its own flags and clears.
// R16: code 100 in both channels stops both counters.
// R17: a 16-bit match compares the joined count with joined compare bytes.
//
// The register offsets and the APB register port are this design's own decisions.
`include "cdt_map.svh"
`default_nettype none
module cdt_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ch0_external_clear_in,
    input  wire logic        ch1_external_clear_in,
    output logic             ch0_wave_out,
    output logic             ch1_wave_out,
    output logic             irq
);
    cdt_pkg::cdt_state_t s_r;
    cdt_pkg::cdt_state_t s_nxt;

    // free-running prescaler tick for one channel clock code
    function automatic logic base_tick(input logic [2:0] cks,
                                       input logic       t8,
                                       input logic       t64);
        case (cks)
            `CDT_CKS_PCLK:  base_tick = 1'b1;
            `CDT_CKS_DIV8:  base_tick = t8;
            `CDT_CKS_DIV64: base_tick = t64;
            default:        base_tick = 1'b0;
        endcase
    endfunction : base_tick

    // next output level from the action codes and this cycle's matches
    function automatic logic wave_next(input logic       cur,
                                       input logic [3:0] os,
                                       input logic       ma,
                                       input logic       mb);
        logic tg;
        logic hi;
        logic lo;
        tg = (ma && os[1:0] == `CDT_OS_TOGGLE)
            || (mb && os[3:2] == `CDT_OS_TOGGLE);
        hi = (ma && os[1:0] == `CDT_OS_HIGH)
            || (mb && os[3:2] == `CDT_OS_HIGH);
        lo = (ma && os[1:0] == `CDT_OS_LOW) || (mb && os[3:2] == `CDT_OS_LOW);
        if (os == 4'h0) begin
            wave_next = 1'b0; // R5
        end else if (tg) begin
            wave_next = ~cur; // R2 R4
        end else if (hi) begin
            wave_next = 1'b1; // R1 R3 R4
        end else if (lo) begin
            wave_next = 1'b0; // R1 R3
        end else begin
            wave_next = cur;
        end
    endfunction : wave_next

    // clear decision from a channel's clear select
    function automatic logic clear_hit(input logic [1:0] cclr,
                                       input logic       ma,
                                       input logic       mb,
                                       input logic       pin);
        case (cclr)
            `CDT_CCLR_MATCH_A: clear_hit = ma;
            `CDT_CCLR_MATCH_B: clear_hit = mb;
            `CDT_CCLR_PIN:     clear_hit = pin;
            default:           clear_hit = 1'b0;
        endcase
    endfunction : clear_hit

    logic        mode16;
    logic        mode_mc;
    logic        t8;
    logic        t64;
    logic        tick0;
    logic        tick1;
    logic        m0a;
    logic        m0b;
    logic        m1a;
    logic        m1b;
    logic        clr0;
    logic        clr1;
    logic        ovf0;
    logic        ovf1;
    logic        pin0;
    logic        pin1;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        hit;
    logic [31:0] rdata;
    logic [5:0]  ev;
    logic [5:0]  rclr;

    // cascade modes and count enables
    always_comb begin
        mode16  = s_r.src0 == `CDT_CKS_CASCADE; // R6 R7
        mode_mc = s_r.src1 == `CDT_CKS_CASCADE; // R6 R14
        t8      = s_r.div[2:0] == `CDT_DIV8_TC;
        t64     = s_r.div == `CDT_DIV64_TC;
        pin0    = s_r.ext0[1] && !s_r.ext0[2];
        pin1    = s_r.ext1[1] && !s_r.ext1[2];
        if (mode16) begin
            // R16: both codes 100 leave no count source
            tick0 = !mode_mc && base_tick(s_r.src1, t8, t64); // R7 R16
            tick1 = tick0;
        end else begin
            tick0 = base_tick(s_r.src0, t8, t64); // R15
            tick1 = 1'b0;
        end
        // 16-bit matches use the joined bytes, else per channel
        if (mode16) begin
            m0a = tick0
                && {s_r.cnt0, s_r.cnt1} == {s_r.cmpa0, s_r.cmpa1}; // R17
            m0b = tick0
                && {s_r.cnt0, s_r.cnt1} == {s_r.cmpb0, s_r.cmpb1}; // R17
        end else begin
            m0a = tick0 && s_r.cnt0 == s_r.cmpa0;
            m0b = tick0 && s_r.cnt0 == s_r.cmpb0;
        end
        if (!mode16) begin
            tick1 = mode_mc ? m0a : base_tick(s_r.src1, t8, t64); // R14
        end
        m1a = tick1 && s_r.cnt1 == s_r.cmpa1; // R9
        m1b = tick1 && s_r.cnt1 == s_r.cmpb1; // R9
        clr0 = clear_hit(s_r.clrm0, m0a, m0b, pin0); // R10 R15
        // low byte never clears alone in 16-bit mode
        clr1 = mode16 ? clr0 : clear_hit(s_r.clrm1, m1a, m1b, pin1); // R10 R11
        ovf1 = tick1 && !clr1 && s_r.cnt1 == `CDT_BYTE_MAX;
        ovf0 = tick0 && !clr0 && s_r.cnt0 == `CDT_BYTE_MAX
            && (!mode16 || s_r.cnt1 == `CDT_BYTE_MAX);
    end

    // apb decode and read mux
    always_comb begin
        acc = psel && penable && s_r.pready;
        wr  = acc && pwrite;
        rd  = acc && !pwrite;
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            `CDT_OFF_CTRL0:    rdata[4:0] = {s_r.clrm0, s_r.src0};
            `CDT_OFF_CTRL1:    rdata[4:0] = {s_r.clrm1, s_r.src1};
            `CDT_OFF_CSR0:     rdata[6:0] = {s_r.stat[2:0], s_r.act0};
            `CDT_OFF_CSR1:     rdata[6:0] = {s_r.stat[5:3], s_r.act1};
            `CDT_OFF_CNT0:     rdata[7:0] = s_r.cnt0;
            `CDT_OFF_CNT1:     rdata[7:0] = s_r.cnt1;
            `CDT_OFF_CMPA0:    rdata[7:0] = s_r.cmpa0;
            `CDT_OFF_CMPA1:    rdata[7:0] = s_r.cmpa1;
            `CDT_OFF_CMPB0:    rdata[7:0] = s_r.cmpb0;
            `CDT_OFF_CMPB1:    rdata[7:0] = s_r.cmpb1;
            `CDT_OFF_IRQ_STAT: rdata[5:0] = s_r.stat;
            `CDT_OFF_IRQ_MASK: rdata[5:0] = s_r.mask;
            default:           hit = 1'b0;
        endcase
        ev   = {ovf1, m1b, m1a, ovf0, m0b, m0a}; // R8 R9 R15
        // clear only the bits returned, so a later event is not lost
        rclr = (rd && paddr == `CDT_OFF_IRQ_STAT) ? s_r.prdata[5:0]
                                                  : `CDT_RST_IRQ;
    end

    // next state: counters, flags, outputs, bus answer
    always_comb begin
        s_nxt = s_r;
        s_nxt.div  = s_r.div + 6'h01;
        s_nxt.ext0 = {s_r.ext0[1:0], ch0_external_clear_in};
        s_nxt.ext1 = {s_r.ext1[1:0], ch1_external_clear_in};
        // counting; clear wins over increment
        if (clr0) begin
            s_nxt.cnt0 = `CDT_RST_BYTE; // R10
        end else if (tick0 && (!mode16 || s_r.cnt1 == `CDT_BYTE_MAX)) begin
            s_nxt.cnt0 = s_r.cnt0 + 8'h01; // R7
        end
        if (clr1) begin
            s_nxt.cnt1 = `CDT_RST_BYTE; // R10 R11
        end else if (tick1) begin
            s_nxt.cnt1 = s_r.cnt1 + 8'h01; // R7 R14
        end
        // waveform outputs per channel
        s_nxt.wave0 = wave_next(s_r.wave0, s_r.act0, m0a, m0b); // R12 R1 R2
        s_nxt.wave1 = wave_next(s_r.wave1, s_r.act1, m1a, m1b); // R13 R1 R2
        // sticky flags: a new event beats the read clear
        s_nxt.stat = (s_r.stat & ~rclr) | ev; // R8 R9
        // register writes at the access edge
        if (wr) begin
            case (paddr)
                `CDT_OFF_CTRL0: begin
                    s_nxt.src0  = pwdata[`CDT_CKS_LSB +: 3];
                    s_nxt.clrm0 = pwdata[`CDT_CCLR_LSB +: 2];
                end
                `CDT_OFF_CTRL1: begin
                    s_nxt.src1  = pwdata[`CDT_CKS_LSB +: 3];
                    s_nxt.clrm1 = pwdata[`CDT_CCLR_LSB +: 2];
                end
                `CDT_OFF_CSR0:     s_nxt.act0  = pwdata[`CDT_OS_LSB +: 4];
                `CDT_OFF_CSR1:     s_nxt.act1  = pwdata[`CDT_OS_LSB +: 4];
                `CDT_OFF_CNT0:     s_nxt.cnt0  = pwdata[7:0];
                `CDT_OFF_CNT1:     s_nxt.cnt1  = pwdata[7:0];
                `CDT_OFF_CMPA0:    s_nxt.cmpa0 = pwdata[7:0];
                `CDT_OFF_CMPA1:    s_nxt.cmpa1 = pwdata[7:0];
                `CDT_OFF_CMPB0:    s_nxt.cmpb0 = pwdata[7:0];
                `CDT_OFF_CMPB1:    s_nxt.cmpb1 = pwdata[7:0];
                `CDT_OFF_IRQ_MASK: s_nxt.mask  = pwdata[5:0];
                default:           s_nxt.mask  = s_r.mask;
            endcase
        end
        // zero-wait answer: data captured in the setup cycle
        s_nxt.pready  = psel && !penable;
        s_nxt.pslverr = psel && !penable && !hit;
        s_nxt.prdata  = (psel && !penable && !pwrite) ? rdata : 32'h0000_0000;
        s_nxt.irq     = |(s_nxt.stat & s_nxt.mask);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r         <= '0;
            s_r.cmpa0   <= `CDT_RST_COMPARE;
            s_r.cmpa1   <= `CDT_RST_COMPARE;
            s_r.cmpb0   <= `CDT_RST_COMPARE;
            s_r.cmpb1   <= `CDT_RST_COMPARE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign prdata       = s_r.prdata;
    assign pready       = s_r.pready;
    assign pslverr      = s_r.pslverr;
    assign ch0_wave_out = s_r.wave0;
    assign ch1_wave_out = s_r.wave1;
    assign irq          = s_r.irq;

    // checks on the output actions, cascade and flags
    property p_match_a_low;
        @(posedge pclk) disable iff (!presetn)
        (s_r.act0 == 4'h1 && m0a && !wr) |=> !ch0_wave_out;
    endproperty
    a_match_a_low: assert property (p_match_a_low) // R1
        else $error("match A low action not applied");

    property p_match_b_toggle;
        @(posedge pclk) disable iff (!presetn)
        (s_r.act1 == 4'hC && m1b && !wr)
            |=> ch1_wave_out != $past(ch1_wave_out);
    endproperty
    a_match_b_toggle: assert property (p_match_b_toggle) // R2
        else $error("match B toggle not applied");

    property p_match_b_high;
        @(posedge pclk) disable iff (!presetn)
        (s_r.act0 == 4'h8 && m0b && !wr) |=> ch0_wave_out;
    endproperty
    a_match_b_high: assert property (p_match_b_high) // R3
        else $error("match B high action not applied");

    property p_priority;
        @(posedge pclk) disable iff (!presetn)
        (s_r.act0 == 4'h6 && m0a && m0b && !wr) |=> ch0_wave_out;
    endproperty
    a_priority: assert property (p_priority) // R4
        else $error("high did not beat low on joint match");

    property p_disabled_low;
        @(posedge pclk) disable iff (!presetn)
        (s_r.act1 == 4'h0 && !wr) |=> !ch1_wave_out;
    endproperty
    a_disabled_low: assert property (p_disabled_low) // R5
        else $error("disabled output not low");

    property p_carry16;
        @(posedge pclk) disable iff (!presetn)
        (mode16 && tick0 && s_r.cnt1 == 8'hFF && !clr0 && !wr)
            |=> s_r.cnt0 == $past(s_r.cnt0) + 8'h01 && s_r.cnt1 == 8'h00;
    endproperty
    a_carry16: assert property (p_carry16) // R7
        else $error("16-bit carry into high byte missing");

    property p_flag16;
        @(posedge pclk) disable iff (!presetn)
        (mode16 && tick0 && {s_r.cnt0, s_r.cnt1} == {s_r.cmpa0, s_r.cmpa1})
            |=> s_r.stat[`CDT_IRQ_CMFA0];
    endproperty
    a_flag16: assert property (p_flag16) // R8
        else $error("16-bit match flag not set");

    property p_clear16;
        @(posedge pclk) disable iff (!presetn)
        (mode16 && s_r.clrm0 == 2'h1 && m0a && !wr)
            |=> s_r.cnt0 == 8'h00 && s_r.cnt1 == 8'h00;
    endproperty
    a_clear16: assert property (p_clear16) // R10
        else $error("16-bit clear missed a byte");

    property p_low_no_clear;
        @(posedge pclk) disable iff (!presetn)
        (mode16 && s_r.clrm0 == 2'h0 && tick0 && s_r.cnt1 != 8'hFF && !wr)
            |=> s_r.cnt1 == $past(s_r.cnt1) + 8'h01;
    endproperty
    a_low_no_clear: assert property (p_low_no_clear) // R11
        else $error("low byte cleared on its own");

    property p_match_count;
        @(posedge pclk) disable iff (!presetn)
        (mode_mc && !mode16 && m0a && !clr1 && !wr)
            |=> s_r.cnt1 == $past(s_r.cnt1) + 8'h01;
    endproperty
    a_match_count: assert property (p_match_count) // R14
        else $error("ch1 missed a ch0 match A");

    property p_both_halt;
        @(posedge pclk) disable iff (!presetn)
        (mode16 && mode_mc && !wr) |=> $stable(s_r.cnt0) && $stable(s_r.cnt1);
    endproperty
    a_both_halt: assert property (p_both_halt) // R16
        else $error("counter moved with both cascade codes");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        irq == |(s_r.stat & s_r.mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level disagrees with status");

    // main scenarios
    c_mode16_match: cover property (@(posedge pclk) disable iff (!presetn)
        mode16 && m0a);
    c_match_count: cover property (@(posedge pclk) disable iff (!presetn)
        mode_mc && !mode16 && m1a);
    c_toggle: cover property (@(posedge pclk) disable iff (!presetn)
        s_r.act0[1:0] == 2'h3 && m0a);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(irq));
endmodule : cdt_timer
`default_nettype wire

// *** bench/cdt_timer_bench.sv ***
// self-checking bench for the cascadable dual 8-bit timer
// assumes cdt_timer and cdt_map.svh from logic/, and acts as the APB master
`include "cdt_map.svh"
`default_nettype none
module cascadable_dual_8bit_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ch0_external_clear_in;
    logic        ch1_external_clear_in;
    logic        ch0_wave_out;
    logic        ch1_wave_out;
    logic        irq;
    int          miscompares;
    int          checks;
    logic [31:0] rd;
    logic        err;

    cdt_timer uut (
        .pclk                  (pclk),
        .presetn               (presetn),
        .psel                  (psel),
        .penable               (penable),
        .pwrite                (pwrite),
        .paddr                 (paddr),
        .pwdata                (pwdata),
        .prdata                (prdata),
        .pready                (pready),
        .pslverr               (pslverr),
        .ch0_external_clear_in (ch0_external_clear_in),
        .ch1_external_clear_in (ch1_external_clear_in),
        .ch0_wave_out          (ch0_wave_out),
        .ch1_wave_out          (ch1_wave_out),
        .irq                   (irq)
    );

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // counts and compares one value against its expectation
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk

    // one APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string n, input logic [11:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, rd);
    endtask : rdchk

    // loads ch0 count, runs ch0 on pclk for a few ticks, then stops it
    task automatic run0(input logic [7:0] start, input logic [4:0] ctl);
        wr(`CDT_OFF_CNT0, {24'h00_0000, start});
        wr(`CDT_OFF_CTRL0, {27'h000_0000, ctl | 5'(`CDT_CKS_PCLK)});
        wr(`CDT_OFF_CTRL0, {27'h000_0000, ctl});
    endtask : run0

    // reset values, idle outputs and an unmapped access
    task automatic t_reset();
        chk("wave0_rst", 32'h0, {31'h0, ch0_wave_out});
        chk("wave1_rst", 32'h0, {31'h0, ch1_wave_out});
        chk("irq_rst", 32'h0, {31'h0, irq});
        rdchk("cmpa0_rst", `CDT_OFF_CMPA0, 32'h0000_00FF);
        rdchk("cnt1_rst", `CDT_OFF_CNT1, 32'h0000_0000);
        rdchk("ctrl0_rst", `CDT_OFF_CTRL0, 32'h0000_0000);
        apb(1'b0, 12'h030, 32'h0000_0000);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_rd", 32'h0, rd);
    endtask : t_reset

    // prescalers: 64 count edges give 8 ticks at /8 and 1 at /64
    task automatic t_div(input logic [2:0] cks, input logic [31:0] e);
        wr(`CDT_OFF_CNT0, 32'h0000_0000);
        wr(`CDT_OFF_CTRL0, {29'h0, cks});
        repeat (61) @(posedge pclk);
        wr(`CDT_OFF_CTRL0, 32'h0000_0000);
        rdchk("cnt0_div", `CDT_OFF_CNT0, e);
    endtask : t_div

    // every action code of one match letter (sh 0 for A, 2 for B)
    task automatic t_out(input int sh);
        logic [1:0] code [5] = '{`CDT_OS_HIGH, `CDT_OS_KEEP, `CDT_OS_LOW,
                                 `CDT_OS_TOGGLE, `CDT_OS_TOGGLE};
        logic       ex   [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [3:0] os;
        wr(`CDT_OFF_CMPA0, (sh == 0) ? 32'h0000_0010 : 32'h0000_00FF);
        wr(`CDT_OFF_CMPB0, (sh == 0) ? 32'h0000_00FF : 32'h0000_0010);
        for (int i = 0; i < 5; i++) begin
            os = 4'(code[i]) << sh;
            // keep needs a nonzero other field, else the pin is forced low
            if (code[i] == `CDT_OS_KEEP) os = 4'h1 << (2 - sh);
            wr(`CDT_OFF_CSR0, {28'h000_0000, os});
            run0(8'h10, 5'h00);
            chk("wave0", {31'h0, ex[i]}, {31'h0, ch0_wave_out});
        end
    endtask : t_out

    // simultaneous A and B matches with conflicting actions
    task automatic t_prio();
        logic [3:0] os [3] = '{4'b1001, 4'b1110, 4'b0111};
        logic       ex [3] = '{1'b1, 1'b0, 1'b1};
        wr(`CDT_OFF_CMPA0, 32'h0000_0010);
        wr(`CDT_OFF_CMPB0, 32'h0000_0010);
        for (int i = 0; i < 3; i++) begin
            wr(`CDT_OFF_CSR0, {28'h000_0000, os[i]});
            run0(8'h10, 5'h00);
            chk("wave0_prio", {31'h0, ex[i]}, {31'h0, ch0_wave_out});
        end
        wr(`CDT_OFF_CMPB0, 32'h0000_00FF);
    endtask : t_prio

    // sticky status, mask and level interrupt
    task automatic t_irq();
        apb(1'b0, `CDT_OFF_IRQ_STAT, 32'h0000_0000);
        wr(`CDT_OFF_IRQ_MASK, 32'h1 << `CDT_IRQ_CMFA0);
        wr(`CDT_OFF_CSR0, 32'h0000_0002);
        run0(8'h10, 5'h00);
        chk("irq_set", 32'h1, {31'h0, irq});
        rdchk("stat_a0", `CDT_OFF_IRQ_STAT, 32'h1 << `CDT_IRQ_CMFA0);
        @(posedge pclk); // irq falls at the clearing edge
        chk("irq_clr", 32'h0, {31'h0, irq});
        rdchk("stat_clr", `CDT_OFF_IRQ_STAT, 32'h0000_0000);
        wr(`CDT_OFF_IRQ_MASK, 32'h0000_0000);
        run0(8'h10, 5'h00);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rdchk("stat_sticky", `CDT_OFF_IRQ_STAT, 32'h1 << `CDT_IRQ_CMFA0);
    endtask : t_irq

    // 16-bit mode: low-byte match alone, then a full 16-bit match
    task automatic t_16();
        logic [31:0] both;
        both = (32'h1 << `CDT_IRQ_CMFA0) | (32'h1 << `CDT_IRQ_CMFA1);
        wr(`CDT_OFF_CTRL1, 32'h0000_0000);
        wr(`CDT_OFF_CTRL0, {29'h0, `CDT_CKS_CASCADE});
        wr(`CDT_OFF_CSR0, 32'h0000_0000);
        wr(`CDT_OFF_CSR0, 32'h0000_0002);
        wr(`CDT_OFF_CSR1, 32'h0000_0002);
        wr(`CDT_OFF_CMPA0, 32'h0000_0099);
        wr(`CDT_OFF_CMPA1, 32'h0000_0034);
        wr(`CDT_OFF_CNT0, 32'h0000_0012);
        wr(`CDT_OFF_CNT1, 32'h0000_0034);
        apb(1'b0, `CDT_OFF_IRQ_STAT, 32'h0000_0000);
        // ch1 asks for clear on match A, which must be ignored here
        wr(`CDT_OFF_CTRL1, 32'h0000_0009);
        wr(`CDT_OFF_CTRL1, 32'h0000_0008);
        rdchk("stat_lo", `CDT_OFF_IRQ_STAT, 32'h1 << `CDT_IRQ_CMFA1);
        chk("wave0_lo", 32'h0, {31'h0, ch0_wave_out});
        chk("wave1_lo", 32'h1, {31'h0, ch1_wave_out});
        rdchk("cnt0_lo", `CDT_OFF_CNT0, 32'h0000_0012);
        rdchk("cnt1_kept", `CDT_OFF_CNT1, 32'h0000_0037);
        // full match with ch0 clear on match A
        wr(`CDT_OFF_CNT1, 32'h0000_0034);
        wr(`CDT_OFF_CMPA0, 32'h0000_0012);
        wr(`CDT_OFF_CTRL0, {27'h0, `CDT_CCLR_MATCH_A, `CDT_CKS_CASCADE});
        wr(`CDT_OFF_CTRL1, 32'h0000_0001);
        wr(`CDT_OFF_CTRL1, 32'h0000_0000);
        rdchk("stat_16", `CDT_OFF_IRQ_STAT, both);
        chk("wave0_16", 32'h1, {31'h0, ch0_wave_out});
        rdchk("cnt0_clr", `CDT_OFF_CNT0, 32'h0000_0000);
        apb(1'b0, `CDT_OFF_CNT1, 32'h0000_0000);
        chk("cnt1_clr", 32'h1, {31'h0, rd < 32'h10});
        wr(`CDT_OFF_CTRL0, 32'h0000_0000);
    endtask : t_16

    // pin clears in 16-bit mode: ch1 pin ignored, ch0 pin clears both
    task automatic t_pin();
        wr(`CDT_OFF_CTRL0, {27'h0, `CDT_CCLR_PIN, `CDT_CKS_CASCADE});
        wr(`CDT_OFF_CTRL1, {27'h0, `CDT_CCLR_PIN, 3'h0});
        wr(`CDT_OFF_CNT0, 32'h0000_0040);
        wr(`CDT_OFF_CNT1, 32'h0000_0041);
        ch1_external_clear_in <= 1'b1;
        repeat (5) @(posedge pclk);
        rdchk("cnt1_pin1", `CDT_OFF_CNT1, 32'h0000_0041);
        ch0_external_clear_in <= 1'b1;
        repeat (5) @(posedge pclk);
        rdchk("cnt0_pin0", `CDT_OFF_CNT0, 32'h0000_0000);
        rdchk("cnt1_pin0", `CDT_OFF_CNT1, 32'h0000_0000);
        ch0_external_clear_in <= 1'b0;
        ch1_external_clear_in <= 1'b0;
        wr(`CDT_OFF_CTRL0, 32'h0000_0000);
        wr(`CDT_OFF_CTRL1, 32'h0000_0000);
    endtask : t_pin

    // ch1 counts ch0 match A events; both in code 100 halts both counters
    task automatic t_cmc();
        wr(`CDT_OFF_CTRL1, {29'h0, `CDT_CKS_CASCADE});
        wr(`CDT_OFF_CNT1, 32'h0000_0000);
        wr(`CDT_OFF_CMPA1, 32'h0000_0000);
        wr(`CDT_OFF_CMPA0, 32'h0000_0010);
        wr(`CDT_OFF_CSR1, 32'h0000_0003);
        apb(1'b0, `CDT_OFF_IRQ_STAT, 32'h0000_0000);
        run0(8'h10, 5'h00);
        rdchk("cnt1_cmc", `CDT_OFF_CNT1, 32'h0000_0001);
        rdchk("stat_cmc", `CDT_OFF_IRQ_STAT, 32'h0000_0009);
        chk("wave1_cmc", 32'h0, {31'h0, ch1_wave_out});
        wr(`CDT_OFF_CNT0, 32'h0000_0050);
        wr(`CDT_OFF_CNT1, 32'h0000_0060);
        wr(`CDT_OFF_CTRL0, {29'h0, `CDT_CKS_CASCADE});
        repeat (20) @(posedge pclk);
        rdchk("cnt0_halt", `CDT_OFF_CNT0, 32'h0000_0050);
        rdchk("cnt1_halt", `CDT_OFF_CNT1, 32'h0000_0060);
    endtask : t_cmc

    // prints the counts and the verdict, then stops the run
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        end_of_test();
    end

    // main sequence
    initial begin
        miscompares = 0;
        checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ch0_external_clear_in = 1'b0;
        ch1_external_clear_in = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_div(`CDT_CKS_DIV8, 32'h0000_0008);
        t_div(`CDT_CKS_DIV64, 32'h0000_0001);
        t_out(0);
        t_out(2);
        t_prio();
        t_irq();
        t_16();
        t_pin();
        t_cmc();
        end_of_test();
    end
endmodule : cascadable_dual_8bit_timer_bench
`default_nettype wire
